// File: src/supply_pkg.sv
// package: register map, field positions, enums and structs for the supply arbiter
package supply_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF     = 8'h00;
   localparam logic [7:0] STATUS_OFF   = 8'h04;
   localparam logic [7:0] EVENT_OFF    = 8'h08;
   localparam logic [7:0] OPTION_OFF   = 8'h0C;
   // control field positions
   localparam int CTRL_CONV_SEL  = 0;
   localparam int CTRL_RANGE_LP  = 1;
   localparam int CTRL_PVD_EN    = 2;
   localparam int CTRL_PVD_FALL  = 3;
   localparam int CTRL_PVD_RISE  = 4;
   localparam int CTRL_WAKE_EN   = 5;
   localparam int CTRL_REFBUF    = 6;
   localparam int CTRL_CLKDET_EN = 7;
   localparam int CTRL_PVD_TH_LO = 8;
   localparam int CTRL_WIDTH     = 11;
   localparam logic [10:0] CTRL_RESET = 11'h000;
   // status field positions
   localparam int ST_CONV_ACT  = 0;
   localparam int ST_LDO_ON    = 1;
   localparam int ST_CONV_ON   = 2;
   localparam int ST_PVD_OUT   = 3;
   localparam int ST_PVM_OK    = 4;
   localparam int ST_EOL       = 5;
   localparam int ST_BATT      = 6;
   localparam int ST_PENDING   = 7;
   localparam int ST_MAINREG   = 8;
   localparam int ST_LPREG     = 9;
   // event field positions (write one to clear)
   localparam int EV_PVD_FALL  = 0;
   localparam int EV_PVD_RISE  = 1;
   localparam int EV_CLK_FAIL  = 2;
   // option field positions
   localparam int OPT_BOR_LVL  = 0;
   localparam logic [2:0] BOR_LEVEL_COUNT = 3'h5;
   localparam logic [2:0] BOR_LEVEL_LOW   = 3'h0;
   // core clock limits in hertz per voltage range
   localparam int unsigned RANGE_HP_MAX_HZ = 48_000_000;
   localparam int unsigned RANGE_LP_MAX_HZ = 16_000_000;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      PM_RUN     = 4'b0001,
      PM_STOP0   = 4'b0010,
      PM_STOP12S = 4'b0100,
      PM_SHUTDN  = 4'b1000
   } power_mode_t;

   typedef enum logic [4:0] {
      RADIO_SLEEP   = 5'b00001,
      RADIO_CALIB   = 5'b00010,
      RADIO_STDBY   = 5'b00100,
      RADIO_STDBYX  = 5'b01000,
      RADIO_ACTIVE  = 5'b10000
   } radio_state_t;

   typedef enum logic [2:0] {
      SUP_LDO    = 3'b001,
      SUP_CONV   = 3'b010,
      SUP_OFF    = 3'b100
   } supply_state_t;

   // analog comparator outputs, all from pins
   typedef struct packed {
      logic vdd_present;
      logic pvd_above;
      logic vdda_ok;
      logic eol_low;
      logic conv_clk_ok;
   } analog_in_t;

   // radio commands
   typedef struct packed {
      radio_state_t state;
      logic         sel_valid;
      logic         sel_conv;
      logic         clkdet_en;
   } radio_req_t;
endpackage

// File: src/supply_mode_arbiter.sv
// supply mode arbiter, supervisor and register slave on AXI4-Lite
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
module supply_mode_arbiter
   import supply_pkg::*;
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   input  wire power_mode_t  power_mode,
   input  wire radio_req_t   radio_req,
   input  wire analog_in_t   analog_pins,
   input  wire logic [2:0]   bor_option,
   input  wire logic         bor_above_lvl,
   input  wire logic         conv_switch_done,
   input  wire logic         wake_source,
   output logic              ldo_enable,
   output logic              conv_enable,
   output logic              brownout_reset,
   output logic              pvd_irq,
   output logic              pvd_wakeup,
   output logic              battery_select,
   output logic              wake_out,
   output logic              refbuf_level_select,
   output logic              range_low_power,
   output logic              flash_extra_wait,
   output logic              main_core_regulator_en,
   output logic              low_power_core_regulator_en
);
   // pins pass two flops before use
   analog_in_t                 ana_meta_reg;
   analog_in_t                 ana_reg;
   logic [2:0]                 bor_sync_meta_reg;
   logic [2:0]                 bor_sync_reg;
   always_ff @(posedge aclk) begin
      ana_meta_reg      <= analog_pins;
      ana_reg           <= ana_meta_reg;
      bor_sync_meta_reg <= {bor_above_lvl, conv_switch_done, wake_source};
      bor_sync_reg      <= bor_sync_meta_reg;
   end
   logic bor_above;
   logic switch_done;
   logic wake_in;
   assign bor_above   = bor_sync_reg[2];
   assign switch_done = bor_sync_reg[1];
   assign wake_in     = bor_sync_reg[0];

   logic [CTRL_WIDTH-1:0] ctrl_reg;
   logic [2:0]            bor_level_reg;
   logic [2:0]            event_reg;
   supply_state_t         sup_reg;
   supply_state_t         sup_next;
   logic                  conv_act_reg;
   logic                  pvd_prev_reg;
   logic                  pending_reg;

   // bus slave: one write and one read under way at a time
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        wr_fire;
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg == CTRL_OFF || awaddr_reg == EVENT_OFF ||
                             awaddr_reg == OPTION_OFF) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic wr_ctrl;
   logic wr_event;
   logic wr_option;
   assign wr_ctrl   = wr_fire && awaddr_reg == CTRL_OFF;
   assign wr_event  = wr_fire && awaddr_reg == EVENT_OFF && wstrb_reg[0];
   assign wr_option = wr_fire && awaddr_reg == OPTION_OFF && wstrb_reg[0];

   // control register, kept in the retained domain so stop/standby keep it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_ctrl) begin
         if (wstrb_reg[0]) ctrl_reg[7:0] <= wdata_reg[7:0];
         if (wstrb_reg[1]) ctrl_reg[CTRL_WIDTH-1:8] <= wdata_reg[CTRL_WIDTH-1:8];
      end
   end

   // brownout option, one of five levels; out-of-range writes ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bor_level_reg <= BOR_LEVEL_LOW;
      end else if (wr_option && wdata_reg[OPT_BOR_LVL +: 3] < BOR_LEVEL_COUNT) begin
         bor_level_reg <= wdata_reg[OPT_BOR_LVL +: 3];
      end
   end

   // brownout: comparator at selected level, lowest level always active
   logic bor_level_on;
   assign bor_level_on   = bor_level_reg == BOR_LEVEL_LOW || power_mode != PM_SHUTDN;
   assign brownout_reset = bor_level_on && !bor_above;

   // radio arbitration
   logic radio_busy;
   logic want_conv;
   logic deep_low;
   logic clk_fail;
   assign radio_busy = radio_req.state == RADIO_STDBYX || radio_req.state == RADIO_ACTIVE;
   assign want_conv  = ctrl_reg[CTRL_CONV_SEL] ||
                       (radio_req.sel_valid && radio_req.sel_conv);
   assign deep_low   = power_mode == PM_STOP12S && radio_req.state != RADIO_ACTIVE;
   assign clk_fail   = (ctrl_reg[CTRL_CLKDET_EN] || radio_req.clkdet_en) &&
                       !ana_reg.conv_clk_ok;

   always_comb begin
      sup_next = sup_reg;
      unique case (sup_reg)
         SUP_OFF: begin
            if (!deep_low) sup_next = ctrl_reg[CTRL_CONV_SEL] ? SUP_CONV : SUP_LDO;
         end
         SUP_LDO: begin
            if (deep_low) sup_next = SUP_OFF;
            else if (want_conv && !radio_busy && !clk_fail) sup_next = SUP_CONV;
         end
         SUP_CONV: begin
            if (clk_fail) sup_next = SUP_LDO;
            else if (deep_low) sup_next = SUP_OFF;
            else if (!want_conv && !radio_busy) sup_next = SUP_LDO;
         end
         default: sup_next = SUP_LDO;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) sup_reg <= SUP_LDO;
      else sup_reg <= sup_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) pending_reg <= 1'b0;
      else pending_reg <= want_conv != (sup_reg == SUP_CONV);
   end

   // status follows only once the analog switch reports done
   always_ff @(posedge aclk) begin
      if (!aresetn) conv_act_reg <= 1'b0;
      else if (switch_done) conv_act_reg <= sup_reg == SUP_CONV;
   end

   // enables: linear always backs up the converter except when off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ldo_enable  <= 1'b1;
         conv_enable <= 1'b0;
      end else begin
         ldo_enable  <= sup_next != SUP_OFF;
         conv_enable <= sup_next == SUP_CONV;
      end
   end

   // core regulators and range
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_core_regulator_en      <= 1'b1;
         low_power_core_regulator_en <= 1'b1;
         range_low_power             <= 1'b0;
         flash_extra_wait            <= 1'b0;
         refbuf_level_select         <= 1'b0;
      end else begin
         main_core_regulator_en      <= power_mode == PM_RUN || power_mode == PM_STOP0;
         low_power_core_regulator_en <= power_mode != PM_SHUTDN;
         range_low_power             <= ctrl_reg[CTRL_RANGE_LP];
         flash_extra_wait            <= ctrl_reg[CTRL_RANGE_LP];
         refbuf_level_select         <= ctrl_reg[CTRL_REFBUF];
      end
   end

   // voltage detector edges
   logic pvd_on;
   logic pvd_fall;
   logic pvd_rise;
   assign pvd_on   = ctrl_reg[CTRL_PVD_EN] && power_mode != PM_SHUTDN;
   assign pvd_fall = pvd_on && pvd_prev_reg && !ana_reg.pvd_above;
   assign pvd_rise = pvd_on && !pvd_prev_reg && ana_reg.pvd_above;

   always_ff @(posedge aclk) begin
      if (!aresetn) pvd_prev_reg <= 1'b1;
      else pvd_prev_reg <= ana_reg.pvd_above;
   end

   // sticky events; a new event beats a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_reg <= 3'h0;
      end else begin
         event_reg <= (event_reg & ~(wr_event ? wdata_reg[2:0] : 3'h0)) |
                      {clk_fail && sup_reg == SUP_CONV,
                       pvd_rise && ctrl_reg[CTRL_PVD_RISE],
                       pvd_fall && ctrl_reg[CTRL_PVD_FALL]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pvd_irq    <= 1'b0;
         pvd_wakeup <= 1'b0;
      end else begin
         pvd_irq    <= event_reg[EV_PVD_FALL] || event_reg[EV_PVD_RISE];
         pvd_wakeup <= pvd_fall && ctrl_reg[CTRL_WAKE_EN];
      end
   end

   // battery domain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         battery_select <= 1'b0;
         wake_out       <= 1'b0;
      end else begin
         battery_select <= !ana_reg.vdd_present;
         wake_out       <= wake_in && ana_reg.vdd_present;
      end
   end

   // read path
   logic [31:0] status_word;
   always_comb begin
      status_word              = 32'h0000_0000;
      status_word[ST_CONV_ACT] = conv_act_reg;
      status_word[ST_LDO_ON]   = ldo_enable;
      status_word[ST_CONV_ON]  = conv_enable;
      status_word[ST_PVD_OUT]  = !ana_reg.pvd_above;
      status_word[ST_PVM_OK]   = ana_reg.vdda_ok;
      status_word[ST_EOL]      = ana_reg.eol_low;
      status_word[ST_BATT]     = battery_select;
      status_word[ST_PENDING]  = pending_reg;
      status_word[ST_MAINREG]  = main_core_regulator_en;
      status_word[ST_LPREG]    = low_power_core_regulator_en;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         unique case (s_axi_araddr)
            CTRL_OFF:   s_axi_rdata <= {21'h0, ctrl_reg};
            STATUS_OFF: s_axi_rdata <= status_word;
            EVENT_OFF:  s_axi_rdata <= {29'h0, event_reg};
            OPTION_OFF: s_axi_rdata <= {29'h0, bor_level_reg};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // checks
   sequence busy_hold_s;
      radio_busy && sup_reg == SUP_LDO && !clk_fail && !deep_low;
   endsequence
   chk_busy_holds_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      busy_hold_s |=> sup_reg == SUP_LDO) else $error("mode changed while radio busy");
   chk_conv_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      sup_reg == SUP_LDO && want_conv && !radio_busy && !clk_fail && !deep_low
      |=> sup_reg == SUP_CONV && conv_enable) else $error("converter request lost");
   chk_clk_fail_ldo: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_fail && sup_reg == SUP_CONV |=> ldo_enable && !conv_enable)
      else $error("clock failure not handled");
   chk_deep_off: assert property (@(posedge aclk) disable iff (!aresetn)
      deep_low && !clk_fail |=> !conv_enable && !ldo_enable) else $error("supplies not off");
   chk_exit_follows_sel: assert property (@(posedge aclk) disable iff (!aresetn)
      sup_reg == SUP_OFF && !deep_low |=> sup_reg == ($past(ctrl_reg[CTRL_CONV_SEL]) ?
      SUP_CONV : SUP_LDO)) else $error("exit mode wrong");
   chk_wake_fall_only: assert property (@(posedge aclk) disable iff (!aresetn)
      pvd_wakeup |-> $past(pvd_fall) && $past(ctrl_reg[CTRL_WAKE_EN]))
      else $error("wakeup not from falling crossing");
   chk_bor_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      !bor_above && bor_level_reg == BOR_LEVEL_LOW |-> brownout_reset)
      else $error("lowest brownout missed");
   chk_status_waits: assert property (@(posedge aclk) disable iff (!aresetn)
      !switch_done |=> $stable(conv_act_reg)) else $error("status moved early");
   chk_batt_no_wake: assert property (@(posedge aclk) disable iff (!aresetn)
      !ana_reg.vdd_present |=> !wake_out && battery_select) else $error("battery exit");
   chk_reset_ldo: assert property (@(posedge aclk)
      !aresetn |=> sup_reg == SUP_LDO && !ctrl_reg[CTRL_CLKDET_EN] && main_core_regulator_en)
      else $error("reset defaults wrong");
endmodule // supply_mode_arbiter

// File: tb/radio_model.sv
// radio subsystem model issuing supply mode requests
`timescale 1ns/100ps
module radio_model
   import supply_pkg::*;
(
   input  wire logic aclk,
   input  wire logic eol_low,
   output radio_req_t radio_req
);
   initial radio_req = '{RADIO_SLEEP, 1'b0, 1'b0, 1'b0};

   // detection goes up one edge ahead of any converter request
   task automatic request(input radio_state_t st, input logic vld, input logic conv);
      @(posedge aclk);
      radio_req.state <= st;
      radio_req.clkdet_en <= 1'b1;
      if (conv)
         @(posedge aclk);
      radio_req.sel_valid <= vld;
      radio_req.sel_conv <= conv;
   endtask

   // supply too low: stop activity and withdraw the request
   always @(posedge aclk) begin
      if (eol_low === 1'b1 && radio_req.state != RADIO_SLEEP) begin
         radio_req.state <= RADIO_SLEEP;
         radio_req.sel_valid <= 1'b0;
      end
   end
endmodule // radio_model

// File: tb/tb.sv
// self-checking bench for the supply mode arbiter
`timescale 1ns/100ps
module tb import supply_pkg::*; ;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   power_mode_t power_mode = PM_RUN;
   radio_req_t  radio_req;
   analog_in_t  analog_pins = 5'h1D;
   logic [2:0]  bor_option = 3'h0;
   logic        bor_above_lvl = 1'b1;
   logic        conv_switch_done = 1'b0;
   logic        wake_source = 1'b0;
   logic        ldo_enable, conv_enable, brownout_reset, pvd_irq, pvd_wakeup;
   logic        battery_select, wake_out, refbuf_level_select, range_low_power;
   logic        flash_extra_wait, main_core_regulator_en, low_power_core_regulator_en;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
   exp_t        q[$];
   exp_t        cur;
   int          n_errors = 0;
   int          tests_run = 0;
   int          seed = 2;
   int          n_wake = 0;
   logic [2:0]  lvl;
   logic [7:0]  cb;

   always #5 aclk = ~aclk;

   supply_mode_arbiter dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode, .radio_req, .analog_pins,
      .bor_option, .bor_above_lvl, .conv_switch_done, .wake_source, .ldo_enable,
      .conv_enable, .brownout_reset, .pvd_irq, .pvd_wakeup, .battery_select, .wake_out,
      .refbuf_level_select, .range_low_power, .flash_extra_wait, .main_core_regulator_en,
      .low_power_core_regulator_en
   );

   radio_model radio_u (.aclk(aclk), .eol_low(analog_pins.eol_low), .radio_req(radio_req));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic pin(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask

   // bounded so a dead handshake cannot hang a single task
   task automatic wait_hi(ref logic s);
      int t;
      t = 0;
      do begin
         @(posedge aclk);
         t++;
      end while (s !== 1'b1 && t < 64);
      if (s !== 1'b1)
         chk("handshake", 32'h0000_0001, 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      q.push_back('{32'h0000_0000, 32'h0000_0000, r});
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin wait_hi(s_axi_awready); s_axi_awvalid <= 1'b0; end
         begin wait_hi(s_axi_wready); s_axi_wvalid <= 1'b0; end
      join
      wait_hi(s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] r);
      q.push_back('{e, m, r});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wait_hi(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      wait_hi(s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // covers the two synchroniser flops plus the registered enables
   task automatic settle;
      repeat (6) @(posedge aclk);
   endtask

   always @(posedge aclk) begin
      if (pvd_wakeup === 1'b1)
         n_wake++;
      if ((s_axi_rvalid & s_axi_rready) === 1'b1 || (s_axi_bvalid & s_axi_bready) === 1'b1) begin
         cur = q.pop_front();
         if (s_axi_rvalid === 1'b1)
            chk("rdata", cur.d & cur.m, s_axi_rdata & cur.m);
         chk("resp", {30'h0, cur.r}, {30'h0, s_axi_rvalid ? s_axi_rresp : s_axi_bresp});
      end
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      $display("ERROR watchdog expected done seen hang");
      print_verdict;
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle;
      pin("ldo_enable", 1'b1, ldo_enable);
      pin("conv_enable", 1'b0, conv_enable);
      pin("main_reg", 1'b1, main_core_regulator_en);
      pin("lp_reg", 1'b1, low_power_core_regulator_en);
      rd(CTRL_OFF, 32'h0000_0000, 32'hFFFF_FFFF, RESP_OKAY);
      rd(STATUS_OFF, 32'h0000_0302, 32'h0000_0387, RESP_OKAY);
      rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(STATUS_OFF, 32'h0000_0001, RESP_SLVERR);
      $display("test reset done");
      wr(CTRL_OFF, 32'h0000_0080, RESP_OKAY);
      wr(CTRL_OFF, 32'h0000_0081, RESP_OKAY);
      settle;
      pin("conv_enable", 1'b1, conv_enable);
      rd(STATUS_OFF, 32'h0000_0004, 32'h0000_0005, RESP_OKAY);
      conv_switch_done <= 1'b1;
      settle;
      rd(STATUS_OFF, 32'h0000_0005, 32'h0000_0005, RESP_OKAY);
      power_mode <= PM_STOP12S;
      settle;
      pin("ldo stop", 1'b0, ldo_enable);
      pin("conv stop", 1'b0, conv_enable);
      rd(CTRL_OFF, 32'h0000_0081, 32'hFFFF_FFFF, RESP_OKAY);
      power_mode <= PM_RUN;
      settle;
      pin("conv wake", 1'b1, conv_enable);
      radio_u.request(RADIO_ACTIVE, 1'b0, 1'b0);
      power_mode <= PM_STOP12S;
      settle;
      pin("conv radio busy", 1'b1, conv_enable);
      power_mode <= PM_RUN;
      wr(CTRL_OFF, 32'h0000_0080, RESP_OKAY);
      radio_u.request(RADIO_SLEEP, 1'b0, 1'b0);
      settle;
      $display("test low power done");
      for (int i = 0; i < 2; i++) begin
         begin
            radio_u.request(i == 0 ? RADIO_STDBYX : RADIO_ACTIVE, 1'b0, 1'b0);
            wr(CTRL_OFF, 32'h0000_0081, RESP_OKAY);
            settle;
            pin("conv frozen", 1'b0, conv_enable);
            rd(STATUS_OFF, 32'h0000_0080, 32'h0000_0081, RESP_OKAY);
            radio_u.request(RADIO_STDBY, 1'b0, 1'b0);
            settle;
            pin("conv released", 1'b1, conv_enable);
            wr(CTRL_OFF, 32'h0000_0080, RESP_OKAY);
            settle;
         end
      end
      radio_u.request(RADIO_STDBY, 1'b1, 1'b1);
      settle;
      pin("conv priority", 1'b1, conv_enable);
      radio_u.request(RADIO_STDBY, 1'b1, 1'b0);
      settle;
      pin("radio ldo", 1'b0, conv_enable);
      radio_u.request(RADIO_SLEEP, 1'b0, 1'b0);
      $display("test arbitration done");
      for (int m = 1; m < 4; m++) begin
         lvl = 3'($random(seed));
         cb = 8'h24 | 8'(m << 3);
         wr(CTRL_OFF, {21'h0, lvl, cb}, RESP_OKAY);
         rd(CTRL_OFF, {21'h0, lvl, cb}, 32'hFFFF_FFFF, RESP_OKAY);
         n_wake = 0;
         analog_pins.pvd_above <= 1'b0;
         settle;
         pin("pvd_irq fall", m[0], pvd_irq);
         chk("wake fall", 32'h0000_0001, 32'(n_wake));
         wr(EVENT_OFF, 32'h0000_0003, RESP_OKAY);
         analog_pins.pvd_above <= 1'b1;
         settle;
         pin("pvd_irq rise", m[1], pvd_irq);
         chk("wake rise", 32'h0000_0001, 32'(n_wake));
         wr(EVENT_OFF, 32'h0000_0003, RESP_OKAY);
      end
      $display("test detector done");
      analog_pins.vdda_ok <= 1'b0;
      wr(CTRL_OFF, 32'h0000_0042, RESP_OKAY);
      settle;
      rd(STATUS_OFF, 32'h0000_0000, 32'h0000_0010, RESP_OKAY);
      pin("refbuf", 1'b1, refbuf_level_select);
      pin("range", 1'b1, range_low_power);
      pin("flash wait", 1'b1, flash_extra_wait);
      analog_pins.vdda_ok <= 1'b1;
      wr(CTRL_OFF, 32'h0000_0080, RESP_OKAY);
      settle;
      rd(STATUS_OFF, 32'h0000_0010, 32'h0000_0010, RESP_OKAY);
      pin("refbuf", 1'b0, refbuf_level_select);
      pin("range", 1'b0, range_low_power);
      analog_pins.vdd_present <= 1'b0;
      settle;
      pin("battery", 1'b1, battery_select);
      wake_source <= 1'b1;
      settle;
      pin("wake blocked", 1'b0, wake_out);
      pin("battery held", 1'b1, battery_select);
      analog_pins.vdd_present <= 1'b1;
      settle;
      pin("battery off", 1'b0, battery_select);
      pin("wake passes", 1'b1, wake_out);
      wake_source <= 1'b0;
      radio_u.request(RADIO_ACTIVE, 1'b0, 1'b0);
      analog_pins.eol_low <= 1'b1;
      settle;
      rd(STATUS_OFF, 32'h0000_0020, 32'h0000_0020, RESP_OKAY);
      analog_pins.eol_low <= 1'b0;
      $display("test monitors done");
      wr(CTRL_OFF, 32'h0000_0081, RESP_OKAY);
      settle;
      analog_pins.conv_clk_ok <= 1'b0;
      settle;
      pin("conv clk fail", 1'b0, conv_enable);
      pin("ldo clk fail", 1'b1, ldo_enable);
      rd(EVENT_OFF, 32'h0000_0004, 32'h0000_0004, RESP_OKAY);
      // drop the converter request first so the returning clock cannot re-select it
      wr(CTRL_OFF, 32'h0000_0080, RESP_OKAY);
      analog_pins.conv_clk_ok <= 1'b1;
      wr(EVENT_OFF, 32'h0000_0004, RESP_OKAY);
      rd(EVENT_OFF, 32'h0000_0000, 32'h0000_0004, RESP_OKAY);
      $display("test clock fail done");
      for (int l = 0; l < 5; l++) begin
         wr(OPTION_OFF, 32'(l), RESP_OKAY);
         rd(OPTION_OFF, 32'(l), 32'h0000_0007, RESP_OKAY);
         bor_above_lvl <= 1'b0;
         settle;
         pin("brownout low", 1'b1, brownout_reset);
         bor_above_lvl <= 1'b1;
         settle;
         pin("brownout high", 1'b0, brownout_reset);
      end
      wr(OPTION_OFF, 32'h0000_0000, RESP_OKAY);
      power_mode <= PM_SHUTDN;
      bor_above_lvl <= 1'b0;
      settle;
      pin("lowest level", 1'b1, brownout_reset);
      wr(OPTION_OFF, 32'h0000_0001, RESP_OKAY);
      settle;
      pin("upper level shutdown", 1'b0, brownout_reset);
      $display("test brownout done");
      print_verdict;
   end
endmodule // tb
